// *** hdl/sadc_ctrl.sv ***
// Purpose: Converter control unit with a classic Wishbone register slave
// Assumes: Comparator and crystal clock arrive from pins; stop_req is same-clock logic
// Notes: Every access acks one cycle after the request; unmapped reads return zero
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module sadc_ctrl
  import sadc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // System
  input wire logic crystal_ref_clock,
  input wire logic stop_req,
  output logic conv_irq,
  // Analog side
  input wire logic comp_above,
  output logic [4:0] mux_channel,
  output logic mux_port_b_enable,
  output logic mux_port_d_enable,
  output logic mux_ref_high,
  output logic mux_ref_low,
  output logic analog_power_on,
  output logic [7:0] trial_code,
  output logic conv_busy
);
  sadc_sar_if sar();

  // Software state
  logic conv_irq_enable;
  logic continuous_mode_bit;
  logic [4:0] channel_select_field;
  logic [2:0] clock_prescale_field;
  logic clock_source_bit;
  logic conversion_done_flag;
  logic armed;

  // Pin synchronisers
  logic comp_meta, comp_sync;
  logic xclk_meta, xclk_sync, xclk_prev;

  // Bus decode
  wire logic bus_req = cyc_i && stb_i && !ack_o;
  wire logic hit_status = (adr_i == SADC_OFS_STATUS_CONTROL);
  wire logic hit_result = (adr_i == SADC_OFS_RESULT);
  wire logic hit_clock = (adr_i == SADC_OFS_CLOCK_SELECT);
  wire logic wr_low = bus_req && we_i && sel_i[0];
  wire logic wr_status = wr_low && hit_status;
  wire logic wr_clock = wr_low && hit_clock;
  wire logic rd_result = bus_req && !we_i && hit_result;

  // Power and start decisions
  wire logic [4:0] new_channel = dat_i[SADC_CHAN_MSB:0];
  wire logic powered = (channel_select_field != SADC_CHAN_OFF);
  wire logic start_write = wr_status && (new_channel != SADC_CHAN_OFF);
  wire logic off_write = wr_status && (new_channel == SADC_CHAN_OFF);
  // Built without start itself, which is derived from this term
  wire logic auto_restart = armed && continuous_mode_bit && powered && !stop_req
    && !sar.busy && !sar.done;
  wire logic flag_clear = wr_status || rd_result;

  // Converter clock source: bus clock every cycle, crystal on its rising edge
  wire logic xclk_rise = xclk_sync && !xclk_prev;
  wire logic src_tick = clock_source_bit ? 1'b1 : xclk_rise;
  logic conv_tick;

  // Read mux
  wire logic [7:0] status_rd = {conversion_done_flag, conv_irq_enable,
    continuous_mode_bit, channel_select_field};
  wire logic [7:0] clock_rd = {clock_prescale_field, clock_source_bit, 4'h0};
  wire logic [7:0] read_byte = hit_status ? status_rd :
    hit_result ? sar.result :
    hit_clock ? clock_rd : 8'h00;

  // Pins come from outside the clock domain; two flops before use
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
      xclk_meta <= 1'b0;
      xclk_sync <= 1'b0;
      xclk_prev <= 1'b0;
    end else begin
      comp_meta <= comp_above;
      comp_sync <= comp_meta;
      xclk_meta <= crystal_ref_clock;
      xclk_sync <= xclk_meta;
      xclk_prev <= xclk_sync;
    end
  end

  // Wishbone answer: one cycle after the request, then low for a cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        dat_o <= {24'h00_0000, read_byte};
      end
    end
  end

  // Status and control register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      conv_irq_enable <= 1'b0;
      continuous_mode_bit <= 1'b0;
      channel_select_field <= SADC_CHAN_RESET;
    end else if (wr_status) begin
      conv_irq_enable <= dat_i[SADC_BIT_IRQ_ENABLE];
      continuous_mode_bit <= dat_i[SADC_BIT_CONTINUOUS];
      channel_select_field <= new_channel;
    end
  end

  // Clock select register; a change mid-conversion corrupts that result
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clock_prescale_field <= SADC_PRESCALE_RESET;
      clock_source_bit <= SADC_SOURCE_RESET;
    end else if (wr_clock) begin
      clock_prescale_field <= dat_i[SADC_PRESCALE_MSB:SADC_PRESCALE_LSB];
      clock_source_bit <= dat_i[SADC_BIT_CLOCK_SOURCE];
    end
  end

  // Done flag doubles as the pending request; a completion beats a clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      conversion_done_flag <= 1'b0;
    end else if (sar.done) begin
      conversion_done_flag <= 1'b1;
    end else if (flag_clear) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // Armed keeps continuous mode going and survives stop, so work resumes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      armed <= 1'b0;
    end else if (off_write) begin
      armed <= 1'b0;
    end else if (start_write) begin
      armed <= 1'b1;
    end else if (sar.done && !continuous_mode_bit) begin
      armed <= 1'b0;
    end
  end

  sadc_clk_div u_div (
    .clock(clock),
    .rst_b(rst_b),
    .src_tick(src_tick),
    .prescale(clock_prescale_field),
    .clear(sar.start),
    .conv_tick(conv_tick)
  );

  sadc_sar u_sar (
    .clock(clock),
    .rst_b(rst_b),
    .sar(sar.engine)
  );

  assign sar.start = (start_write || auto_restart) && !stop_req;
  assign sar.abort = stop_req || off_write;
  assign sar.tick = conv_tick;
  // Comparator lags two system cycles; a converter clock must span at least two
  assign sar.comp_above = comp_sync;

  // Analog multiplexer steering
  assign mux_channel = channel_select_field;
  assign mux_port_b_enable = (channel_select_field <= SADC_CHAN_LAST_PORT_B);
  assign mux_port_d_enable = (channel_select_field > SADC_CHAN_LAST_PORT_B)
    && (channel_select_field <= SADC_CHAN_LAST_PORT_D);
  // Unused and reserved codes select nothing; the result is then meaningless
  assign mux_ref_high = (channel_select_field == SADC_CHAN_REF_HIGH);
  assign mux_ref_low = (channel_select_field == SADC_CHAN_REF_LOW);
  assign analog_power_on = powered && !stop_req;
  assign trial_code = sar.trial;
  assign conv_busy = sar.busy;
  assign conv_irq = conversion_done_flag && conv_irq_enable;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Converter clocks since the last start, for the conversion length check
  logic [7:0] since_start;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      since_start <= 8'h00;
    end else if (sar.start) begin
      since_start <= 8'h00;
    end else if (conv_tick && since_start != 8'hFF) begin
      since_start <= since_start + 8'h01;
    end
  end

  irq_on_done_a: assert property (sar.done && conv_irq_enable |=> conv_irq)
    else $error("completion with enable set gave no request");
  irq_clear_a: assert property (flag_clear && !sar.done |=> !conv_irq)
    else $error("request survived a clearing access");
  irq_reset_a: assert property ($rose(rst_b) |-> !conv_irq_enable)
    else $error("interrupt enable not clear after reset");
  cont_restart_a: assert property (sar.done && continuous_mode_bit && armed && powered
    && !stop_req && !wr_status |-> ##[1:2] sar.busy)
    else $error("continuous mode did not restart");
  single_idle_a: assert property (sar.start && !start_write
    |-> continuous_mode_bit && armed)
    else $error("single mode converted again");
  off_no_start_a: assert property (off_write |=> !sar.busy && !analog_power_on)
    else $error("power-off code left converter running");
  conv_len_a: assert property (sar.done |-> since_start == 8'(SADC_TICKS_PER_CONV))
    else $error("conversion did not take sixteen converter clocks");
  done_flag_a: assert property (sar.done |=> conversion_done_flag)
    else $error("done flag not set at completion");
  stop_abort_a: assert property (stop_req && sar.busy |=> !sar.busy)
    else $error("stop did not abort the conversion");
  result_load_a: assert property (sar.done
    |-> sar.result[7:1] == $past(sar.trial[7:1]) && sar.result[0] == $past(sar.comp_above))
    else $error("result does not hold the final trial decision");
  bus_ack_a: assert property (bus_req |=> ack_o ##1 !ack_o)
    else $error("bus answer not a single cycle after request");
  port_route_a: assert property (mux_port_b_enable |-> channel_select_field[4:3] == 2'b00)
    else $error("port B routed for a high channel code");
  port_d_route_a: assert property (mux_port_d_enable
    |-> channel_select_field[4:3] == 2'b01 && channel_select_field != 5'h0F)
    else $error("port D routed for a code outside its range");
  ref_route_a: assert property (mux_ref_high || mux_ref_low
    |-> channel_select_field[4:2] == 3'b111
    && channel_select_field[1] != channel_select_field[0])
    else $error("reference node routed for a wrong code");
  unused_quiet_a: assert property (channel_select_field inside {[5'h0F:5'h1C]}
    |-> !mux_port_b_enable && !mux_port_d_enable && !mux_ref_high && !mux_ref_low)
    else $error("unused channel code routed an input");
  power_off_a: assert property (channel_select_field == SADC_CHAN_OFF
    |-> !analog_power_on && !sar.busy)
    else $error("converter active with the power-off code");
  reset_state_a: assert property ($rose(rst_b)
    |-> !continuous_mode_bit && channel_select_field == SADC_CHAN_RESET && !clock_source_bit)
    else $error("control fields not at reset values");
  start_write_a: assert property (start_write && !stop_req |=> sar.busy)
    else $error("status write did not start a conversion");
  result_only_a: assert property ($changed(sar.result) |-> sar.done)
    else $error("result changed without a completion");
  trial_first_a: assert property (sar.start && !sar.abort |=> sar.trial == 8'h80)
    else $error("conversion did not begin with the top bit");
  flag_read_a: assert property (rd_result && !sar.done |=> !conversion_done_flag)
    else $error("result read left the done flag set");

  cov_single_c: cover property (start_write ##[1:300] sar.done);
  cov_cont_c: cover property (sar.done && continuous_mode_bit ##[1:300] sar.done);
  cov_stop_c: cover property (sar.busy && stop_req);
  cov_irq_c: cover property (conv_irq ##[1:20] rd_result);
  cov_off_c: cover property (sar.busy && off_write);
endmodule // sadc_ctrl

// *** hdl/sadc_pkg.sv ***
// Purpose: Shared constants for the successive-approximation converter control
// Assumes: Registers sit one per aligned 32-bit word on the register bus
// Notes: Data lives in the low byte of each word; upper bits read zero
package sadc_pkg;
  // Register byte addresses
  localparam logic [3:0] SADC_OFS_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] SADC_OFS_RESULT = 4'h4;
  localparam logic [3:0] SADC_OFS_CLOCK_SELECT = 4'h8;
  // Status and control field positions
  localparam int SADC_BIT_DONE = 7;
  localparam int SADC_BIT_IRQ_ENABLE = 6;
  localparam int SADC_BIT_CONTINUOUS = 5;
  localparam int SADC_CHAN_MSB = 4;
  // Clock select field positions
  localparam int SADC_PRESCALE_MSB = 7;
  localparam int SADC_PRESCALE_LSB = 5;
  localparam int SADC_BIT_CLOCK_SOURCE = 4;
  // Reset values
  localparam logic [4:0] SADC_CHAN_RESET = 5'h1F;
  localparam logic [2:0] SADC_PRESCALE_RESET = 3'h0;
  localparam logic SADC_SOURCE_RESET = 1'b0;
  // Channel codes of note
  localparam logic [4:0] SADC_CHAN_OFF = 5'h1F;
  localparam logic [4:0] SADC_CHAN_LAST_PORT_B = 5'h07;
  localparam logic [4:0] SADC_CHAN_LAST_PORT_D = 5'h0E;
  localparam logic [4:0] SADC_CHAN_RESERVED = 5'h1B;
  localparam logic [4:0] SADC_CHAN_REF_HIGH = 5'h1D;
  localparam logic [4:0] SADC_CHAN_REF_LOW = 5'h1E;
  // Timing: two converter clocks per result bit
  localparam int SADC_RESULT_BITS = 8;
  localparam int SADC_TICKS_PER_CONV = 16;
  localparam logic [3:0] SADC_DIV_MAX = 4'hF;
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_SETTLE = 2'b01,
    SADC_DECIDE = 2'b10
  } sadc_state_t;
endpackage

// *** hdl/sadc_sar_if.sv ***
// Purpose: Carries control and results between the control unit and the approximation engine
// Assumes: Single clock domain
// Notes: All signals are plain nets driven by one side each
`timescale 1ns/1ps
interface sadc_sar_if;
  logic start;
  logic abort;
  logic tick;
  logic comp_above;
  logic busy;
  logic done;
  logic [7:0] result;
  logic [7:0] trial;
  modport ctrl (output start, output abort, output tick, output comp_above,
    input busy, input done, input result, input trial);
  modport engine (input start, input abort, input tick, input comp_above,
    output busy, output done, output result, output trial);
endinterface // sadc_sar_if

// *** hdl/sadc_clk_div.sv ***
// Purpose: Converter clock enable from a source enable and a prescale code
// Assumes: src_tick is a system-clock enable, high every cycle for the bus clock or one cycle per crystal rising edge
// Notes: Codes 0..3 divide by 1,2,4,8; any code with the top bit set by 16
`timescale 1ns/1ps
module sadc_clk_div
  import sadc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic src_tick,
  input wire logic [2:0] prescale,
  input wire logic clear,
  // Result
  output logic conv_tick
);
  logic [3:0] count;
  wire logic [3:0] last_count = prescale[2] ? SADC_DIV_MAX :
    4'((5'h01 << prescale[1:0]) - 5'h01);
  wire logic at_last = (count >= last_count);

  assign conv_tick = src_tick && at_last;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= 4'h0;
    end else if (clear || conv_tick) begin
      count <= 4'h0;
    end else if (src_tick) begin
      count <= count + 4'h1;
    end
  end
endmodule // sadc_clk_div

// *** hdl/sadc_sar.sv ***
// Purpose: Successive-approximation engine, one bit per two converter clocks
// Assumes: comp_above is high when the input is at or above the trial code
// Notes: A settle tick precedes each decide tick, giving sixteen ticks per result
`timescale 1ns/1ps
module sadc_sar
  import sadc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control side
  sadc_sar_if.engine sar
);
  sadc_state_t state;
  logic [2:0] bit_idx;
  logic [7:0] acc;
  wire logic [7:0] bit_mask = 8'h01 << bit_idx;
  wire logic last_bit = (bit_idx == 3'h0);

  assign sar.busy = (state != SADC_IDLE);
  assign sar.trial = acc;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= SADC_IDLE;
      bit_idx <= 3'h7;
      acc <= 8'h00;
      sar.result <= 8'h00;
      sar.done <= 1'b0;
    end else begin
      sar.done <= 1'b0;
      if (sar.abort) begin
        state <= SADC_IDLE;
      end else if (sar.start) begin
        state <= SADC_SETTLE;
        bit_idx <= 3'h7;
        acc <= 8'h80;
      end else if (sar.tick) begin
        case (state)
          SADC_SETTLE: begin
            state <= SADC_DECIDE;
          end
          SADC_DECIDE: begin
            // Keep the trial bit only if the input is at or above it
            if (last_bit) begin
              state <= SADC_IDLE;
              sar.result <= sar.comp_above ? acc : (acc & ~bit_mask);
              sar.done <= 1'b1;
            end else begin
              state <= SADC_SETTLE;
              bit_idx <= bit_idx - 3'h1;
              acc <= (sar.comp_above ? acc : (acc & ~bit_mask)) | (bit_mask >> 1);
            end
          end
          default: begin
            state <= SADC_IDLE;
          end
        endcase
      end
    end
  end
endmodule // sadc_sar

// *** dv/sadc_analog_model.sv ***
// Purpose: Analog multiplexer and comparator stand-in for the converter bench
// Assumes: Every routed input holds a fixed level derived from its channel code
// Notes: An unrouted or unpowered comparator toggles each cycle, so a stale level never passes
`timescale 1ns/1ps
module sadc_analog_model (
  // Clock
  input wire logic clock,
  // Multiplexer controls
  input wire logic [4:0] mux_channel,
  input wire logic mux_port_b_enable,
  input wire logic mux_port_d_enable,
  input wire logic mux_ref_high,
  input wire logic mux_ref_low,
  input wire logic analog_power_on,
  // Comparator
  input wire logic [7:0] trial_code,
  output logic comp_above
);
  logic toggle;
  logic routed;
  logic [7:0] level;
  assign level = mux_ref_high ? 8'hFF : (mux_ref_low ? 8'h00 : {mux_channel[3:0], 4'h5});
  assign routed = analog_power_on && (mux_port_b_enable || mux_port_d_enable
    || mux_ref_high || mux_ref_low);
  initial toggle = 1'b0;
  always @(posedge clock) begin
    toggle <= !toggle;
  end
  assign comp_above = routed ? (level >= trial_code) : toggle;
endmodule // sadc_analog_model

// *** dv/tb_sar_adc_control_unit.sv ***
// Purpose: Register-level bench for the converter control unit
// Assumes: Bus clock at 100 MHz, crystal pin at 20 MHz
// Notes: Conversion lengths are checked with a small tolerance for synchroniser delay
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_sar_adc_control_unit;
  import sadc_pkg::*;
  logic clock, rst_b, cyc_i, stb_i, we_i, ack_o, stop_req, crystal_ref_clock;
  logic conv_irq, comp_above, mux_port_b_enable, mux_port_d_enable;
  logic mux_ref_high, mux_ref_low, analog_power_on, conv_busy;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [4:0] mux_channel;
  logic [7:0] trial_code;
  int err_total = 0;
  int tests_run = 0;
  int n;
  int div;
  logic [3:0] route;
  assign route = {mux_port_b_enable, mux_port_d_enable, mux_ref_high, mux_ref_low};
  sadc_ctrl dut (.clock(clock), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .crystal_ref_clock(crystal_ref_clock), .stop_req(stop_req), .conv_irq(conv_irq),
    .comp_above(comp_above), .mux_channel(mux_channel), .mux_port_b_enable(mux_port_b_enable),
    .mux_port_d_enable(mux_port_d_enable), .mux_ref_high(mux_ref_high),
    .mux_ref_low(mux_ref_low), .analog_power_on(analog_power_on), .trial_code(trial_code),
    .conv_busy(conv_busy));
  sadc_analog_model analog (.clock(clock), .mux_channel(mux_channel),
    .mux_port_b_enable(mux_port_b_enable), .mux_port_d_enable(mux_port_d_enable),
    .mux_ref_high(mux_ref_high), .mux_ref_low(mux_ref_low),
    .analog_power_on(analog_power_on), .trial_code(trial_code), .comp_above(comp_above));
  function automatic logic [3:0] exp_route(input int c);
    return (c < 8) ? 4'h8 : (c < 15) ? 4'h4 : (c == 29) ? 4'h2 : 4'h1;
  endfunction
  function automatic logic [7:0] exp_val(input int c);
    return (c == 29) ? 8'hFF : (c == 30) ? 8'h00 : {4'(c), 4'h5};
  endfunction
  task automatic print_verdict;
    $display("counts: %0d compares, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clock);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    sel_i <= 4'hF;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clock);
      k++;
    end while (ack_o !== 1'b1);
    rd = dat_o;
    `CHK("ack delay", 2, k)
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] ex, input string nm);
    wb(1'b0, a, 8'h00);
    `CHK(nm, {24'h0, ex}, rd)
  endtask
  task automatic wait_idle(input int lim);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (conv_busy !== 1'b0 && n < lim);
    // One more edge so that state set at completion can be seen
    @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    crystal_ref_clock = 1'b0;
    // Offset keeps pin edges away from the sampling edge
    #2;
    forever #25 crystal_ref_clock = ~crystal_ref_clock;
  end
  initial begin
    #300000;
    err_total++;
    print_verdict;
  end
  initial begin
    rst_b = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 4'h0;
    sel_i = 4'h0;
    dat_i = 32'h0;
    stop_req = 1'b0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rchk(SADC_OFS_STATUS_CONTROL, 8'h1F, "status");
    rchk(SADC_OFS_RESULT, 8'h00, "result");
    rchk(SADC_OFS_CLOCK_SELECT, 8'h00, "clksel");
    `CHK("power", 1'b0, analog_power_on)
    rchk(4'hC, 8'h00, "unmapped");
    $display("test reset done");
    // First conversion after power-up is a throwaway
    for (int p = 0; p < 8; p++) begin
      div = p[2] ? 16 : (1 << p);
      wb(1'b1, SADC_OFS_CLOCK_SELECT, {p[2:0], 5'h10});
      wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h1D);
      wait_idle(400);
      `CHK("length", 1'b1, (n >= 16 * div - 3 && n <= 16 * div + 3))
    end
    rchk(SADC_OFS_CLOCK_SELECT, 8'hF0, "clksel");
    // Divide by 16 gives the synchronised comparator time to settle per decision
    wb(1'b1, SADC_OFS_CLOCK_SELECT, 8'h90);
    $display("test prescale done");
    for (int c = 0; c < 31; c++) begin
      if (c > 14 && c < 29) continue;
      wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'(c));
      `CHK("route", exp_route(c), route)
      `CHK("chan", 5'(c), mux_channel)
      wait_idle(400);
      `CHK("irq off", 1'b0, conv_irq)
      rchk(SADC_OFS_STATUS_CONTROL, {3'b100, 5'(c)}, "done");
      rchk(SADC_OFS_RESULT, exp_val(c), "result");
      rchk(SADC_OFS_STATUS_CONTROL, {3'b000, 5'(c)}, "done clr");
    end
    wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h10);
    `CHK("route", 4'h0, route)
    `CHK("power", 1'b1, analog_power_on)
    wait_idle(400);
    $display("test channels done");
    wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h40);
    wait_idle(400);
    `CHK("irq", 1'b1, conv_irq)
    rchk(SADC_OFS_RESULT, 8'h05, "result");
    `CHK("irq", 1'b0, conv_irq)
    wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h41);
    wait_idle(400);
    `CHK("irq", 1'b1, conv_irq)
    wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h41);
    `CHK("irq", 1'b0, conv_irq)
    wait_idle(400);
    $display("test interrupt done");
    wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h3D);
    wait_idle(400);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (conv_busy !== 1'b1 && n < 5);
    `CHK("restart", 1'b1, conv_busy)
    wait_idle(400);
    wait_idle(400);
    rchk(SADC_OFS_RESULT, 8'hFF, "result");
    wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h1F);
    `CHK("busy", 1'b0, conv_busy)
    `CHK("power", 1'b0, analog_power_on)
    repeat (40) @(posedge clock);
    `CHK("busy", 1'b0, conv_busy)
    wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h03);
    wait_idle(400);
    repeat (40) @(posedge clock);
    `CHK("busy", 1'b0, conv_busy)
    $display("test modes done");
    wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h03);
    repeat (5) @(posedge clock);
    stop_req <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK("busy", 1'b0, conv_busy)
    `CHK("power", 1'b0, analog_power_on)
    stop_req <= 1'b0;
    wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h1F);
    $display("test stop done");
    // Crystal divided by 16 puts the converter clock at 1.25 MHz
    wb(1'b1, SADC_OFS_CLOCK_SELECT, 8'h80);
    // First conversion after power-up only lets the analog side settle
    wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h02);
    wait_idle(1500);
    wb(1'b1, SADC_OFS_STATUS_CONTROL, 8'h02);
    wait_idle(1500);
    // Sixteen to seventeen converter clocks of eighty system cycles, plus phase
    `CHK("length", 1'b1, (n >= 1270 && n <= 1365))
    rchk(SADC_OFS_RESULT, 8'h25, "result");
    $display("test crystal done");
    print_verdict;
  end
endmodule // tb_sar_adc_control_unit
